// [kwi_pkg.sv]
// Purpose: constants shared by the key wake interrupt unit
// Assumes: one bus clock, synchronous pin inputs
// Notes: status/control bit positions mirror the register layout
package kwi_pkg;
    localparam int KWI_PINS = 8;
    localparam int KWI_SC_MODE_BIT = 0;
    localparam int KWI_SC_IRQEN_BIT = 1;
    localparam int KWI_SC_ACK_BIT = 2;
    localparam int KWI_SC_FLAG_BIT = 3;
    localparam logic [7:0] KWI_SC_RESET = 8'h00;
    localparam logic [7:0] KWI_PE_RESET = 8'h00;
    localparam logic [7:0] KWI_ES_RESET = 8'h00;
    localparam logic KWI_FLAG_RESET = 1'b0;
    localparam logic KWI_ARM_RESET = 1'b0;
endpackage : kwi_pkg

// [kwi_pin_detect.sv]
// Purpose: per-pin polarity and enable qualification with edge sampling
// Assumes: inputs synchronous to clk
// Notes: a disabled pin reports neither asserted nor edge
`timescale 1ns/1ps
`default_nettype none
module kwi_pin_detect #(
    parameter int PINS = kwi_pkg::KWI_PINS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [PINS-1:0] wake_input_pin,
    input wire logic [PINS-1:0] pin_enable_register,
    input wire logic [PINS-1:0] polarity_register,
    output logic [PINS-1:0] asserted,
    output logic [PINS-1:0] edge_seen
);
    logic [PINS-1:0] prev_asserted;
    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            // polarity 0 means low is asserted, 1 means high
            always_comb begin
                asserted[i] = pin_enable_register[i] &
                    (polarity_register[i] ? wake_input_pin[i] : ~wake_input_pin[i]);
                edge_seen[i] = asserted[i] & ~prev_asserted[i];
            end
        end
    endgenerate

    // previous sample; on first enable prev is 0 so an already asserted pin can flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_asserted <= '0;
        end else begin
            prev_asserted <= asserted;
        end
    end
endmodule : kwi_pin_detect
`default_nettype wire

// [kwi_unit.sv]
// Purpose: key wake interrupt unit, eight pins, one shared flag
// Assumes: control bits are plain ports written synchronously by the host side
// Notes: acknowledge is a one-cycle write strobe
// Function
// - up to eight pins, each individually enabled; disabled pins do nothing
// - one mode bit picks edge-only or edge-and-level for all pins
// - per-pin polarity picks falling/low or rising/high
// - falling edge: sampled high one cycle, low the next
// - rising edge: sampled low one cycle, high the next
// - no new edge until all enabled pins return deasserted
// - edge-only: valid edge sets flag; acknowledge write clears it
// - edge-and-level: edge or asserted level sets flag
// - interrupt request whenever flag and interrupt enable are both set
// - edge-and-level: acknowledge clears only when all enabled pins deasserted
// - request doubles as wake-up from stop or wait
// - pullup choice per enabled pin passes to port pull control
// - spurious flag on first enable can be cleared by later acknowledge
// - flag is read-only at status bit 3; writes do not change it
// - polarity bit zero falling/low, one rising/high
// - pin enable one enables the pin, zero disables it
// - mode bit clear edges only, set edges and levels
`timescale 1ns/1ps
`default_nettype none
module kwi_unit #(
    parameter int PINS = kwi_pkg::KWI_PINS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [PINS-1:0] wake_input_pin,
    input wire logic [PINS-1:0] pin_enable_register,
    input wire logic [PINS-1:0] polarity_register,
    input wire logic [PINS-1:0] pullup_select,
    input wire logic detect_mode_select,
    input wire logic irq_enable,
    input wire logic flag_acknowledge,
    output logic event_flag,
    output logic irq,
    output logic wake_request,
    output logic [7:0] status_control_register,
    output logic [PINS-1:0] pullup_enable
);
    logic [PINS-1:0] asserted;
    logic [PINS-1:0] edge_seen;
    logic any_asserted;
    logic armed;
    logic valid_edge;
    logic set_flag;
    logic clear_ok;
    logic next_flag;

    kwi_pin_detect #(.PINS(PINS)) u_detect (
        .clk(clk),
        .rst(rst),
        .wake_input_pin(wake_input_pin),
        .pin_enable_register(pin_enable_register),
        .polarity_register(polarity_register),
        .asserted(asserted),
        .edge_seen(edge_seen)
    );

    always_comb begin
        any_asserted = |asserted;
        valid_edge = armed & (|edge_seen);
        // edge-and-level adds the asserted level as a set source
        set_flag = valid_edge | (detect_mode_select & any_asserted);
        clear_ok = flag_acknowledge & ~(detect_mode_select & any_asserted);
        // set wins over clear when both land in one cycle
        next_flag = set_flag | (event_flag & ~clear_ok);
    end

    // armed once every enabled pin sits deasserted; an edge disarms
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed <= kwi_pkg::KWI_ARM_RESET;
        end else if (valid_edge) begin
            armed <= 1'b0;
        end else if (!any_asserted) begin
            armed <= 1'b1;
        end
    end

    // flag has no write path, only set and acknowledge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_flag <= kwi_pkg::KWI_FLAG_RESET;
        end else begin
            event_flag <= next_flag;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            irq <= next_flag & irq_enable;
            // wake follows irq so a masked unit never wakes the core
            wake_request <= next_flag & irq_enable;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_control_register <= kwi_pkg::KWI_SC_RESET;
        end else begin
            status_control_register <= '0;
            status_control_register[kwi_pkg::KWI_SC_FLAG_BIT] <= next_flag;
            status_control_register[kwi_pkg::KWI_SC_IRQEN_BIT] <= irq_enable;
            status_control_register[kwi_pkg::KWI_SC_MODE_BIT] <= detect_mode_select;
        end
    end

    // pull only applies to pins enabled as wake inputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pullup_enable <= '0;
        end else begin
            pullup_enable <= pullup_select & pin_enable_register;
        end
    end

    AST_IRQ_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
        irq == (event_flag & $past(irq_enable)))
        else $error("irq mismatch with flag and enable");
    AST_LEVEL_HOLDS: assert property (@(posedge clk) disable iff (rst)
        (detect_mode_select & any_asserted) |=> event_flag)
        else $error("flag cleared while level asserted");
    AST_ACK_CLEARS: assert property (@(posedge clk) disable iff (rst)
        (flag_acknowledge & ~set_flag & ~(detect_mode_select & any_asserted)) |=> !event_flag)
        else $error("acknowledge did not clear flag");
    AST_EDGE_SETS: assert property (@(posedge clk) disable iff (rst)
        valid_edge |=> event_flag)
        else $error("edge did not set flag");
    AST_NO_REARM: assert property (@(posedge clk) disable iff (rst)
        (valid_edge ##1 any_asserted) |-> !valid_edge)
        else $error("new edge before all pins deasserted");
    AST_DISABLED_QUIET: assert property (@(posedge clk) disable iff (rst)
        (pin_enable_register == '0) |-> (asserted == '0 && edge_seen == '0))
        else $error("disabled pins produced activity");
    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (rst)
        (event_flag & ~flag_acknowledge) |=> event_flag)
        else $error("flag dropped without acknowledge");
    AST_NO_SPONT_SET: assert property (@(posedge clk) disable iff (rst)
        (!event_flag & !set_flag) |=> !event_flag)
        else $error("flag set without cause");
    AST_PULL_GATED: assert property (@(posedge clk) disable iff (rst)
        pullup_enable == $past(pullup_select & pin_enable_register))
        else $error("pullup not gated by pin enable");
    AST_WAKE_MATCH: assert property (@(posedge clk) disable iff (rst)
        wake_request == irq)
        else $error("wake differs from irq");

    COV_EDGE_IRQ: cover property (@(posedge clk) disable iff (rst)
        valid_edge & irq_enable ##1 irq);
    COV_LEVEL_BLOCKED_ACK: cover property (@(posedge clk) disable iff (rst)
        event_flag & flag_acknowledge & detect_mode_select & any_asserted);
    COV_ACK_CLEAR: cover property (@(posedge clk) disable iff (rst)
        event_flag & clear_ok & ~set_flag ##1 !event_flag);
endmodule : kwi_unit
`default_nettype wire

// [kwi_switch_model.sv]
// Purpose: external switches driving the wake pins
// Assumes: bench sets switch levels just after clk rise
// Notes: a released pin floats unless its pullup is on
`timescale 1ns/1ps
`default_nettype none
module kwi_switch_model (
    input wire logic clk,
    input wire logic [7:0] drive_en,
    input wire logic [7:0] drive_val,
    input wire logic [7:0] pullup_enable,
    output logic [7:0] wake_input_pin
);
    logic [7:0] wander = 8'h00;
    // floating pin wanders so no fixed level is read by luck
    always @(posedge clk) wander <= ~wander;
    assign wake_input_pin = (drive_en & drive_val) | (~drive_en & (pullup_enable | wander));
endmodule : kwi_switch_model
`default_nettype wire

// [tb_top.sv]
// Purpose: scenarios for the key wake interrupt unit
// Assumes: 25 MHz clk, inputs driven 1 ns after rise
// Notes: fixed 3-cycle settle covers the 1-cycle flag latency
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst = 1'b1, mode = 1'b0, irqen = 1'b0, ack = 1'b0;
    logic [7:0] pe = 8'h00, pol = 8'h00, pus = 8'h00, den = 8'hFF, dval = 8'hFF;
    logic [7:0] pin, sc, pue;
    logic flag, irq, wake;
    int error_cnt = 0, checked = 0;
    always #20 clk = ~clk;
    kwi_switch_model SW (.clk(clk), .drive_en(den), .drive_val(dval),
        .pullup_enable(pue), .wake_input_pin(pin));
    kwi_unit DUT (.clk(clk), .rst(rst), .wake_input_pin(pin), .pin_enable_register(pe),
        .polarity_register(pol), .pullup_select(pus), .detect_mode_select(mode),
        .irq_enable(irqen), .flag_acknowledge(ack), .event_flag(flag), .irq(irq),
        .wake_request(wake), .status_control_register(sc), .pullup_enable(pue));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic pins(input logic [7:0] v);
        dval = v;
        tick(3);
    endtask : pins
    task automatic do_ack();
        ack = 1'b1;
        tick(1);
        ack = 1'b0;
        tick(2);
    endtask : do_ack
    task automatic t_falling();
        irqen = 1'b1;
        pe = 8'h01;
        pins(8'hFF);
        check(flag, 8'h00);
        pins(8'hFE);
        check(flag, 8'h01);
        check({irq, wake}, 8'h03);
        check(sc, 8'h0A);
        do_ack();
        check(flag, 8'h00);
        pins(8'hFF);
        pins(8'hFE);
        check(flag, 8'h01);
        do_ack();
        check(sc, 8'h02);
    endtask : t_falling
    task automatic t_rising();
        dval = 8'h7F;
        pol = 8'h80;
        pe = 8'h80;
        tick(3);
        do_ack();
        check(flag, 8'h00);
        pins(8'hFF);
        check(flag, 8'h01);
        pins(8'h7F);
        do_ack();
    endtask : t_rising
    task automatic t_disabled();
        pol = 8'h00;
        pe = 8'h01;
        pins(8'hFF);
        do_ack();
        pins(8'hFD);
        pins(8'hFF);
        check(flag, 8'h00);
        mode = 1'b1;
        pins(8'hFD);
        check(flag, 8'h00);
        pins(8'hFC);
        check(flag, 8'h01);
        do_ack();
        check(sc, 8'h0B);
        pins(8'hFD);
        do_ack();
        check(flag, 8'h00);
        mode = 1'b0;
    endtask : t_disabled
    task automatic t_pullup();
        irqen = 1'b0;
        pol = 8'h10;
        pus = 8'hF0;
        pe = 8'h30;
        tick(3);
        check(pue, 8'h30);
        check(flag, 8'h01);
        check({irq, wake}, 8'h00);
        do_ack();
        check(flag, 8'h00);
        irqen = 1'b1;
        tick(2);
        check({irq, wake}, 8'h00);
    endtask : t_pullup
    task automatic close_out();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        tick(6);
        rst = 1'b0;
        check(sc, 8'h00);
        t_falling();
        t_rising();
        t_disabled();
        t_pullup();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
